// ---- shared/modbus_slave_pkg.sv ----
// constants, state type and helpers for the modbus rtu slave
// Overview of operation
// RULE_01: each character is one start, eight data, two stop bits, no parity.
// RULE_02: station address zero is a broadcast that every controller executes.
// RULE_03: a broadcast request never gets a response.
// RULE_04: function 03 reads holding registers, at most 121 per request.
// RULE_05: function 06 writes exactly one holding register.
// RULE_06: function 16 writes consecutive registers, at most 25 per request.
// RULE_07: a request failing its crc is dropped silently, registers untouched.
// RULE_08: a request with byte or word count faults is dropped silently.
// RULE_09: a well formed request with a bad value gets an exception response.
// RULE_10: an unsupported function code returns error code 1.
// RULE_11: an invalid data register address returns error code 2.
// RULE_12: a register count above the function limit returns error code 4.
// RULE_13: parameters are reached only through holding registers 40001 to 49999.
// RULE_14: all parameters read; read-only ones are never changed by writes.
// RULE_15: nonzero level parameters take writes only after the matching password.
// RULE_16: level zero parameters take writes with no password.
// RULE_17: password 1111 written to the access level unlocks level 1.
// RULE_18: first and optional second port behave identically.
// RULE_19: each writable parameter has a level compared with the unlocked level.
// RULE_20: parameters not read-only support both reads and writes.
// RULE_21: frames are delimited by an idle gap of at least 3.5 characters.
// RULE_22: exceptions echo address, function with top bit set, code and crc.
// RULE_23: writes to read-only or locked parameters leave the value unchanged.
package modbus_slave_pkg;
	localparam int CLK_HZ        = 40_000_000;
	localparam int BAUD          = 9600;
	localparam int CLKS_PER_BIT  = CLK_HZ / BAUD;
	localparam int DATA_BITS     = 8;
	localparam int STOP_BITS     = 2;
	localparam int CHAR_BITS     = 1 + DATA_BITS + STOP_BITS;
	localparam logic [3:0] RX_STOP_BIT = 4'h9;
	localparam int GAP_CHARS_X2  = 7;
	localparam int GAP_BITS      = (GAP_CHARS_X2 * CHAR_BITS + 1) / 2;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [7:0] FC_READ    = 8'h03;
	localparam logic [7:0] FC_WRITE1  = 8'h06;
	localparam logic [7:0] FC_WRITEN  = 8'h10;
	localparam logic [7:0] EXC_FLAG   = 8'h80;
	localparam logic [7:0] EXC_FUNC   = 8'h01;
	localparam logic [7:0] EXC_ADDR   = 8'h02;
	localparam logic [7:0] EXC_COUNT  = 8'h04;
	localparam logic [15:0] MAX_READ  = 16'h0079;
	localparam logic [15:0] MAX_WRITE = 16'h0019;
	localparam logic [15:0] PASSWORD_L1 = 16'h0457;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] CRC_INIT  = 16'hffff;
	localparam logic [15:0] CRC_POLY  = 16'ha001;
	localparam int REG_COUNT     = 47;
	localparam int IDX_W         = 6;
	localparam int BUF_DEPTH     = 64;
	localparam logic [IDX_W-1:0] ACCESS_IDX = 6'h00;
	localparam logic [IDX_W-1:0] PORT2_IDX  = 6'h01;
	localparam logic [IDX_W-1:0] RO_FIRST   = 6'h08;
	localparam logic [IDX_W-1:0] RO_LAST    = 6'h0b;
	localparam logic [IDX_W-1:0] STATUS_IDX = 6'h0b;
	localparam logic [6:0] MIN_LEN   = 7'h04;
	localparam logic [6:0] FIXED_LEN = 7'h08;
	localparam logic [8:0] MULTI_OVH = 9'h009;
	localparam logic [5:0] DATA_POS  = 6'h07;
	localparam logic [7:0] READ_HDR  = 8'h03;
	localparam logic [7:0] ECHO_LEN  = 8'h06;
	localparam logic [7:0] EXC_LEN   = 8'h03;

	typedef enum logic [1:0] {
		S_RX    = 2'b00,
		S_CHECK = 2'b01,
		S_EXEC  = 2'b11,
		S_TX    = 2'b10
	} state_t;

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	function automatic logic reg_ro(input logic [IDX_W-1:0] idx);
		return idx >= RO_FIRST && idx <= RO_LAST;
	endfunction

	function automatic logic reg_level(input logic [IDX_W-1:0] idx);
		return idx == PORT2_IDX;
	endfunction
endpackage

// ---- hw/byte_uart.sv ----
// serial character receiver and transmitter with bit-rate divider
`timescale 1ns/1ps
`default_nettype none
module byte_uart
	import modbus_slave_pkg::*;
#(
	parameter int CLKS_PER_BIT_P = CLKS_PER_BIT
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       rxd,
	output wire logic       txd,
	input  wire logic       tx_go,
	input  wire logic [7:0] tx_byte,
	output wire logic       tx_busy,
	output wire logic       rx_valid,
	output wire logic [7:0] rx_byte,
	output wire logic       rx_busy,
	output wire logic       bit_tick
);
	// divider needs at least two clocks per bit
	localparam int CW = $clog2(CLKS_PER_BIT_P);
	localparam logic [CW-1:0] BIT_LAST = CW'(CLKS_PER_BIT_P - 1);
	localparam logic [CW-1:0] HALF     = CW'(CLKS_PER_BIT_P / 2 - 1);

	logic [CW-1:0] div_q;
	logic [CW-1:0] rcnt_q;
	logic [3:0]    rbit_q;
	logic [3:0]    tn_q;
	logic [7:0]    rsh_q;
	logic [10:0]   tsh_q;
	logic          tick_q;
	logic          txd_q;
	logic          tx_busy_q;
	logic          rx_busy_q;
	logic          rx_valid_q;

	assign txd      = txd_q;
	assign tx_busy  = tx_busy_q;
	assign rx_valid = rx_valid_q;
	assign rx_byte  = rsh_q;
	assign rx_busy  = rx_busy_q;
	assign bit_tick = tick_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= div_q == BIT_LAST;
			div_q  <= (div_q == BIT_LAST) ? '0 : div_q + 1'b1;
		end
	end

	// receiver realigns its own timing on each start edge
	always_ff @(posedge clk) begin
		rx_valid_q <= 1'b0;
		if (!resetn) begin
			rx_busy_q <= 1'b0;
			rcnt_q    <= '0;
			rbit_q    <= '0;
			rsh_q     <= '0;
		end else if (!rx_busy_q) begin
			if (!rxd) begin
				rx_busy_q <= 1'b1;
				rcnt_q    <= HALF;
				rbit_q    <= '0;
			end
		end else if (rcnt_q != '0) begin
			rcnt_q <= rcnt_q - 1'b1;
		end else begin
			rcnt_q <= BIT_LAST;
			rbit_q <= rbit_q + 1'b1;
			if (rbit_q == 4'h0 && rxd) begin
				rx_busy_q <= 1'b0;
			end else if (rbit_q == RX_STOP_BIT) begin
				// a low stop bit drops the character, so the frame crc fails
				rx_busy_q  <= 1'b0;
				rx_valid_q <= rxd; // RULE_01
			end else if (rbit_q != 4'h0) begin
				rsh_q <= {rxd, rsh_q[7:1]}; // RULE_01
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			txd_q     <= 1'b1;
			tx_busy_q <= 1'b0;
			tn_q      <= '0;
			tsh_q     <= '1;
		end else if (tx_go && !tx_busy_q) begin
			tx_busy_q <= 1'b1;
			tsh_q     <= {2'b11, tx_byte, 1'b0}; // RULE_01
			tn_q      <= 4'(CHAR_BITS);
		end else if (tx_busy_q && tick_q) begin
			if (tn_q == 4'h0) begin
				tx_busy_q <= 1'b0;
			end else begin
				txd_q <= tsh_q[0];
				tsh_q <= {1'b1, tsh_q[10:1]};
				tn_q  <= tn_q - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- hw/modbus_rtu_slave.sv ----
// modbus rtu slave: framing, checks, register store and responses
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave
	import modbus_slave_pkg::*;
#(
	parameter int CLKS_PER_BIT_P = CLKS_PER_BIT,
	parameter int REGS           = REG_COUNT
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             rxd,
	output wire logic             txd,
	input  wire logic [7:0]       station_addr,
	input  wire logic [15:0]      live_status,
	output logic                  param_wr,
	output logic [IDX_W-1:0]      param_idx,
	output logic [15:0]           param_data
);
	state_t           state_q;
	logic [7:0]       buf_q [BUF_DEPTH];
	logic [15:0]      regs_q [REGS];
	logic [6:0]       len_q;
	logic [15:0]      crc_q;
	logic [5:0]       gap_q;
	logic             exc_q;
	logic             bcast_q;
	logic [7:0]       code_q;
	logic [7:0]       k_q;
	logic [4:0]       widx_q;
	logic             tx_go_q;
	logic [7:0]       tx_byte_q;
	logic             param_wr_q;
	logic [IDX_W-1:0] param_idx_q;
	logic [15:0]      param_data_q;

	wire       rx_valid;
	wire [7:0] rx_byte;
	wire       rx_busy;
	wire       tx_busy;
	wire       bit_tick;

	assign param_wr   = param_wr_q;
	assign param_idx  = param_idx_q;
	assign param_data = param_data_q;

	// one instance per serial port; a second port is a second copy of this block
	byte_uart #(.CLKS_PER_BIT_P(CLKS_PER_BIT_P)) u_uart ( // RULE_18
		.clk      (clk),
		.resetn   (resetn),
		.rxd      (rxd),
		.txd      (txd),
		.tx_go    (tx_go_q),
		.tx_byte  (tx_byte_q),
		.tx_busy  (tx_busy),
		.rx_valid (rx_valid),
		.rx_byte  (rx_byte),
		.rx_busy  (rx_busy),
		.bit_tick (bit_tick)
	);

	// request fields
	wire [7:0]  fc    = buf_q[1];
	wire [15:0] start = {buf_q[2], buf_q[3]};
	wire [15:0] qty   = {buf_q[4], buf_q[5]};
	wire [7:0]  bcnt  = buf_q[6];
	wire        fc_rd = fc == FC_READ;
	wire        fc_w1 = fc == FC_WRITE1;
	wire        fc_wn = fc == FC_WRITEN;

	wire frame_end = state_q == S_RX && len_q != 7'h00 && gap_q == 6'(GAP_BITS) && !rx_busy; // RULE_21
	wire bcast     = buf_q[0] == BCAST_ADDR; // RULE_02
	wire ours      = bcast || buf_q[0] == station_addr;

	// fixed-length functions must be exactly eight bytes
	wire syn_fixed = len_q != FIXED_LEN;
	wire syn_multi = len_q < FIXED_LEN || {2'b00, len_q} != {1'b0, bcnt} + MULTI_OVH
		|| qty[15:7] != 9'h000 || bcnt != {qty[6:0], 1'b0};
	wire syn_bad   = (fc_rd || fc_w1) ? syn_fixed : fc_wn ? syn_multi : 1'b0; // RULE_08
	wire discard   = crc_q != 16'h0000 || len_q < MIN_LEN || !ours || syn_bad; // RULE_07

	wire fc_bad  = !(fc_rd || fc_w1 || fc_wn); // RULE_10
	wire cnt_bad = fc_rd ? (qty == 16'h0000 || qty > MAX_READ) // RULE_04
		: fc_wn ? (qty == 16'h0000 || qty > MAX_WRITE) : 1'b0; // RULE_06
	// register space starts at 40001; addresses past the store are refused
	wire [16:0] end_addr = {1'b0, start} + (fc_w1 ? 17'h00001 : {1'b0, qty}); // RULE_05
	wire        addr_bad = end_addr > 17'(REGS); // RULE_13
	wire        exc_now  = fc_bad || cnt_bad || addr_bad; // RULE_09
	wire [7:0]  exc_code = fc_bad ? EXC_FUNC : cnt_bad ? EXC_COUNT : EXC_ADDR; // RULE_10 RULE_11 RULE_12

	// write path
	wire              unlocked = regs_q[ACCESS_IDX] == PASSWORD_L1; // RULE_17
	wire [IDX_W-1:0]  wr_idx   = start[IDX_W-1:0] + {1'b0, widx_q};
	wire [5:0]        dpos     = DATA_POS + {widx_q, 1'b0};
	wire [15:0]       wr_data  = fc_w1 ? qty : {buf_q[dpos], buf_q[dpos + 6'h01]};
	wire              lvl_ok   = !reg_level(wr_idx) || unlocked; // RULE_15 RULE_16 RULE_19
	wire              wr_ok    = !reg_ro(wr_idx) && lvl_ok; // RULE_14 RULE_20 RULE_23
	wire              wr_last  = fc_w1 || {11'h000, widx_q} + 16'h0001 == qty;

	// response bytes
	wire [7:0]        body_len = exc_q ? EXC_LEN : fc_rd ? READ_HDR + {qty[6:0], 1'b0} : ECHO_LEN;
	wire [7:0]        rd_off   = k_q - READ_HDR;
	wire [IDX_W-1:0]  rd_idx   = start[IDX_W-1:0] + rd_off[IDX_W:1];
	wire [15:0]       rd_word  = rd_idx == STATUS_IDX ? live_status : regs_q[rd_idx]; // RULE_14
	wire [7:0]        rd_b     = rd_off[0] ? rd_word[7:0] : rd_word[15:8];
	wire [7:0]        hdr2     = exc_q ? code_q : fc_rd ? {qty[6:0], 1'b0} : buf_q[2];
	wire [7:0]        body_b   = k_q == 8'h00 ? buf_q[0]
		: k_q == 8'h01 ? (exc_q ? fc | EXC_FLAG : fc) // RULE_22
		: k_q == 8'h02 ? hdr2
		: fc_rd ? rd_b : buf_q[k_q[5:0]];
	wire [7:0]        tx_b     = k_q < body_len ? body_b : k_q == body_len ? crc_q[7:0] : crc_q[15:8];
	wire              tx_done  = k_q == body_len + 8'h02;
	wire              tx_slot  = !tx_busy && !tx_go_q;

	// receive buffer; bytes past the buffer are counted but not stored
	always_ff @(posedge clk) begin
		if (state_q == S_RX && rx_valid && len_q < 7'(BUF_DEPTH)) begin
			buf_q[len_q[5:0]] <= rx_byte;
		end
	end

	// silence gap counter, cleared by any line activity
	always_ff @(posedge clk) begin
		if (!resetn || state_q != S_RX || rx_busy) begin
			gap_q <= '0;
		end else if (bit_tick && gap_q != 6'(GAP_BITS)) begin
			gap_q <= gap_q + 6'h01; // RULE_21
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < REGS; i++) begin
				regs_q[i] <= REG_RESET;
			end
		end else if (state_q == S_EXEC && wr_ok) begin
			regs_q[wr_idx] <= wr_data; // RULE_05 RULE_06
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			param_wr_q   <= 1'b0;
			param_idx_q  <= '0;
			param_data_q <= '0;
		end else begin
			param_wr_q   <= state_q == S_EXEC && wr_ok;
			param_idx_q  <= wr_idx;
			param_data_q <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		tx_go_q <= 1'b0;
		if (!resetn) begin
			state_q   <= S_RX;
			len_q     <= '0;
			crc_q     <= CRC_INIT;
			exc_q     <= 1'b0;
			bcast_q   <= 1'b0;
			code_q    <= '0;
			k_q       <= '0;
			widx_q    <= '0;
			tx_byte_q <= '0;
		end else begin
			case (state_q)
			S_RX: begin
				if (rx_valid) begin
					len_q <= (len_q == 7'h7f) ? len_q : len_q + 7'h01;
					crc_q <= crc_step(crc_q, rx_byte);
				end else if (frame_end) begin
					state_q <= S_CHECK;
				end
			end
			S_CHECK: begin
				len_q   <= '0;
				crc_q   <= CRC_INIT;
				exc_q   <= exc_now;
				code_q  <= exc_code;
				bcast_q <= bcast;
				k_q     <= '0;
				widx_q  <= '0;
				if (discard) begin
					state_q <= S_RX; // RULE_07 RULE_08
				end else if (exc_now || fc_rd) begin
					state_q <= bcast ? S_RX : S_TX; // RULE_03
				end else begin
					state_q <= S_EXEC;
				end
			end
			S_EXEC: begin
				widx_q <= widx_q + 5'h01;
				if (wr_last) begin
					state_q <= bcast_q ? S_RX : S_TX; // RULE_03
				end
			end
			S_TX: begin
				// bytes heard while answering are ignored; half duplex line
				if (tx_slot) begin
					if (tx_done) begin
						state_q <= S_RX;
						crc_q   <= CRC_INIT;
					end else begin
						tx_go_q   <= 1'b1;
						tx_byte_q <= tx_b;
						k_q       <= k_q + 8'h01;
						if (k_q < body_len) begin
							crc_q <= crc_step(crc_q, tx_b);
						end
					end
				end
			end
			default: state_q <= S_RX;
			endcase
		end
	end

	property p_bcast_quiet;
		@(posedge clk) disable iff (!resetn)
		(bcast_q && state_q != S_RX) |-> state_q != S_TX;
	endproperty
	a_bcast_quiet: assert property (p_bcast_quiet) else $error("broadcast answered"); // RULE_03

	property p_crc_drop;
		@(posedge clk) disable iff (!resetn)
		(state_q == S_CHECK && crc_q != 16'h0000) |=> state_q == S_RX ##1 !param_wr;
	endproperty
	a_crc_drop: assert property (p_crc_drop) else $error("bad crc not dropped"); // RULE_07

	property p_syntax_drop;
		@(posedge clk) disable iff (!resetn)
		(state_q == S_CHECK && syn_bad) |=> state_q == S_RX && !tx_go_q;
	endproperty
	a_syntax_drop: assert property (p_syntax_drop) else $error("syntax fault not dropped"); // RULE_08

	property p_exc_func;
		@(posedge clk) disable iff (!resetn)
		(state_q == S_CHECK && !discard && fc_bad) |=> exc_q && code_q == EXC_FUNC;
	endproperty
	a_exc_func: assert property (p_exc_func) else $error("wrong code for bad function"); // RULE_10

	property p_exc_count;
		@(posedge clk) disable iff (!resetn)
		(state_q == S_CHECK && !discard && !fc_bad && cnt_bad) |=> exc_q && code_q == EXC_COUNT;
	endproperty
	a_exc_count: assert property (p_exc_count) else $error("wrong code for bad count"); // RULE_12

	property p_exc_addr;
		@(posedge clk) disable iff (!resetn)
		(state_q == S_CHECK && !discard && !exc_code[0] && !cnt_bad && addr_bad) |=> code_q == EXC_ADDR;
	endproperty
	a_exc_addr: assert property (p_exc_addr) else $error("wrong code for bad address"); // RULE_11

	property p_ro_kept;
		@(posedge clk) disable iff (!resetn)
		param_wr |-> !reg_ro(param_idx) && regs_q[param_idx] == param_data;
	endproperty
	a_ro_kept: assert property (p_ro_kept) else $error("read-only parameter written"); // RULE_14

	property p_level_gate;
		@(posedge clk) disable iff (!resetn)
		(param_wr && reg_level(param_idx)) |-> $past(regs_q[ACCESS_IDX]) == PASSWORD_L1;
	endproperty
	a_level_gate: assert property (p_level_gate) else $error("locked parameter written"); // RULE_15

	property p_txd_rest;
		@(posedge clk) disable iff (!resetn)
		state_q != S_TX |-> txd;
	endproperty
	a_txd_rest: assert property (p_txd_rest) else $error("line not idle outside an answer"); // RULE_01

	property p_wr_in_exec;
		@(posedge clk) disable iff (!resetn)
		param_wr |-> $past(state_q) == S_EXEC && !exc_q;
	endproperty
	a_wr_in_exec: assert property (p_wr_in_exec) else $error("write outside execution"); // RULE_09

	property p_single_write;
		@(posedge clk) disable iff (!resetn)
		(state_q == S_EXEC && fc_w1) |=> state_q != S_EXEC;
	endproperty
	a_single_write: assert property (p_single_write) else $error("single write ran twice"); // RULE_05

	property p_write_span;
		@(posedge clk) disable iff (!resetn)
		state_q == S_EXEC |-> {11'h000, widx_q} < MAX_WRITE;
	endproperty
	a_write_span: assert property (p_write_span) else $error("too many words written"); // RULE_06

	property p_read_ok;
		@(posedge clk) disable iff (!resetn)
		(state_q == S_CHECK && !discard && fc_rd && qty != 16'h0000 && qty <= MAX_READ && !addr_bad)
			|=> !exc_q && state_q != S_EXEC;
	endproperty
	a_read_ok: assert property (p_read_ok) else $error("legal read refused"); // RULE_04

	property p_exc_top_bit;
		@(posedge clk) disable iff (!resetn)
		(state_q == S_TX && exc_q && tx_slot && k_q == 8'h01)
			|=> tx_go_q && tx_byte_q[7] && tx_byte_q[6:0] == fc[6:0];
	endproperty
	a_exc_top_bit: assert property (p_exc_top_bit) else $error("exception function byte wrong"); // RULE_22

	property p_foreign_drop;
		@(posedge clk) disable iff (!resetn)
		(state_q == S_CHECK && !bcast && buf_q[0] != station_addr) |=> state_q == S_RX;
	endproperty
	a_foreign_drop: assert property (p_foreign_drop) else $error("foreign station frame taken"); // RULE_02
endmodule
`default_nettype wire

// ---- testbench/modbus_host.sv ----
// serial host model: sends request characters, decodes answer characters
`timescale 1ns/1ps
`default_nettype none
module modbus_host #(
	parameter int CPB = 8
) (
	input  wire logic       clk,
	input  wire logic       txd,
	output logic            rxd,
	output logic            got,
	output logic [7:0]      got_byte,
	output logic            got_ok
);
	logic [10:0] sh;

	initial begin
		rxd = 1'b1;
		got = 1'b0;
		got_byte = 8'h00;
		got_ok = 1'b0;
	end

	// line rests high between characters and frames
	task automatic send_byte(input logic [7:0] b);
		logic [10:0] f;
		f = {2'b11, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd <= f[i];
			repeat (CPB) @(posedge clk);
		end
	endtask

	// mid-bit sampling, like a real receiver
	always begin
		@(negedge txd);
		repeat (CPB / 2) @(posedge clk);
		sh[0] = txd;
		for (int i = 1; i < 11; i++) begin
			repeat (CPB) @(posedge clk);
			sh[i] = txd;
		end
		got_byte <= sh[8:1];
		got_ok <= (sh[0] === 1'b0) && (sh[10:9] === 2'b11);
		got <= 1'b1;
		@(posedge clk);
		got <= 1'b0;
	end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench: host requests, register map reference, answer and write checks
`timescale 1ns/1ps
`default_nettype none
module testbench
	import modbus_slave_pkg::*;
;
	localparam int CPB = 8;
	localparam logic [7:0] SA = 8'h11;
	typedef logic [7:0] bq_t [$];
	logic             clk;
	logic             resetn;
	logic             rxd;
	logic             txd;
	logic             param_wr;
	logic             got;
	logic             got_ok;
	logic [7:0]       station_addr;
	logic [7:0]       got_byte;
	logic [15:0]      live_status;
	logic [15:0]      param_data;
	logic [IDX_W-1:0] param_idx;
	logic [15:0]      regs [REG_COUNT];
	logic [7:0]       exp_tx [$];
	logic [21:0]      exp_wr [$];
	logic [31:0]      lfsr;
	bq_t              q;
	int               fail_count;
	int               n_checks;

	modbus_rtu_slave #(.CLKS_PER_BIT_P(CPB), .REGS(REG_COUNT)) dut (.clk(clk), .resetn(resetn), .rxd(rxd),
		.txd(txd), .station_addr(station_addr), .live_status(live_status), .param_wr(param_wr),
		.param_idx(param_idx), .param_data(param_data));
	modbus_host #(.CPB(CPB)) host (.clk(clk), .txd(txd), .rxd(rxd), .got(got), .got_byte(got_byte),
		.got_ok(got_ok));

	always #12.5 clk = ~clk;

	function automatic logic [15:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[15:0];
	endfunction

	// own crc, kept apart from the design's helper
	function automatic logic [15:0] crc16(input bq_t b);
		logic [15:0] c;
		c = 16'hffff;
		foreach (b[k]) begin
			c = c ^ {8'h00, b[k]};
			for (int i = 0; i < 8; i++) begin
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
			end
		end
		return c;
	endfunction

	function automatic bq_t fr(input logic [7:0] a, input logic [7:0] fc, input logic [15:0] st,
		input logic [15:0] v, input int bc = -1, input int nb = 0);
		bq_t b;
		b = '{a, fc, st[15:8], st[7:0], v[15:8], v[7:0]};
		if (bc >= 0)
			b.push_back(8'(bc));
		for (int i = 0; i < nb; i++)
			b.push_back(8'(rnd()));
		return b;
	endfunction

	task automatic check(input string what, input logic [21:0] e, input logic [21:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// oldest note against each result as it appears
	always @(posedge clk) begin
		if (got === 1'b1) begin
			check("stop bits", 22'h1, {21'h0, got_ok});
			if (exp_tx.size() == 0)
				check("unexpected answer byte", 22'h3fffff, {14'h0, got_byte});
			else
				check("answer byte", {14'h0, exp_tx.pop_front()}, {14'h0, got_byte});
		end
		if (param_wr === 1'b1) begin
			if (exp_wr.size() == 0)
				check("unexpected write", 22'h3fffff, {param_idx, param_data});
			else
				check("param write", exp_wr.pop_front(), {param_idx, param_data});
		end
	end

	task automatic wr(input int i, input logic [15:0] v);
		if ((i >= 8 && i <= 11) || (i == 1 && regs[0] !== 16'h0457))
			return;
		regs[i] = v;
		exp_wr.push_back({6'(i), v});
	endtask

	// reference answer, then send and wait out the answer and the idle gap
	task automatic run(input bq_t b, input bit bad);
		bq_t r;
		logic [15:0] c, st, qty;
		int n, bc, k, lim;
		bit ok;
		c = crc16(b) ^ {15'h0, bad};
		n = b.size() + 2;
		st = {b[2], b[3]};
		qty = {b[4], b[5]};
		bc = (n > 8) ? int'(b[6]) : -1;
		lim = (b[1] == 8'h03) ? 121 : 25;
		ok = !bad && (b[0] == station_addr || b[0] == 8'h00);
		if (ok && !(b[1] inside {8'h03, 8'h06, 8'h10}))
			r = '{b[0], b[1] | 8'h80, 8'h01};
		else if (ok && b[1] != 8'h10 && n != 8)
			ok = 0;
		else if (ok && b[1] == 8'h10 && (n != 9 + bc || bc != 2 * qty))
			ok = 0;
		else if (ok && b[1] != 8'h06 && (qty == 0 || qty > lim))
			r = '{b[0], b[1] | 8'h80, 8'h04};
		else if (ok && int'(st) + ((b[1] == 8'h06) ? 1 : int'(qty)) > REG_COUNT)
			r = '{b[0], b[1] | 8'h80, 8'h02};
		else if (ok && b[1] == 8'h03) begin
			r = '{b[0], b[1], 8'(2 * qty)};
			for (int i = 0; i < qty; i++) begin
				r.push_back((st + i == 11) ? live_status[15:8] : regs[st + i][15:8]);
				r.push_back((st + i == 11) ? live_status[7:0] : regs[st + i][7:0]);
			end
		end else if (ok) begin
			for (int i = 0; i < ((b[1] == 8'h06) ? 1 : int'(qty)); i++)
				wr(st + i, (b[1] == 8'h06) ? qty : {b[7 + 2 * i], b[8 + 2 * i]});
			r = b[0:5];
		end
		if (r.size() > 0 && b[0] != 8'h00) begin
			st = crc16(r);
			r.push_back(st[7:0]);
			r.push_back(st[15:8]);
			exp_tx = {exp_tx, r};
		end
		foreach (b[i])
			host.send_byte(b[i]);
		host.send_byte(c[7:0]);
		host.send_byte(c[15:8]);
		for (k = 0; k < 30000 && (exp_tx.size() > 0 || exp_wr.size() > 0); k++)
			@(posedge clk);
		if (k == 30000) begin
			fail_count++;
			$display("MISMATCH completion expected idle seen pending");
			give_verdict();
		end
		repeat (60 * CPB) @(posedge clk);
	endtask

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		station_addr = SA;
		live_status = 16'h0000;
		lfsr = 32'h249e4a0d;
		fail_count = 0;
		n_checks = 0;
		foreach (regs[i])
			regs[i] = 16'h0000;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		live_status <= rnd();
		repeat (2) @(posedge clk);
		run(fr(SA, 8'h03, 0, 47), 0);
		run(fr(SA, 8'h06, 1, 16'h1234), 0);
		run(fr(SA, 8'h06, 0, 16'h0457), 0);
		run(fr(SA, 8'h06, 1, rnd()), 0);
		run(fr(SA, 8'h06, 9, rnd()), 0);
		run(fr(SA, 8'h10, 6, 6, 12, 12), 0);
		run(fr(SA, 8'h10, 20, 25, 50, 50), 0);
		run(fr(SA, 8'h10, 20, 26, 52, 52), 0);
		run(fr(SA, 8'h03, 0, 0), 0);
		run(fr(SA, 8'h03, 0, 122), 0);
		run(fr(SA, 8'h03, 0, 121), 0);
		run(fr(SA, 8'h03, 46, 2), 0);
		run(fr(SA, 8'h06, 47, 1), 0);
		q.delete();
		q = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h0f, 8'h17, 8'h43};
		foreach (q[i])
			run(fr(SA, q[i], 0, 1), 0);
		run(fr(SA, 8'h06, 3, rnd()), 1);
		run(fr(SA, 8'h06, 3, rnd(), 0), 0);
		run(fr(SA, 8'h10, 3, 2, 4, 2), 0);
		run(fr(8'h00, 8'h06, 4, rnd()), 0);
		run(fr(8'h00, 8'h03, 0, 4), 0);
		run(fr(8'h12, 8'h06, 5, rnd()), 0);
		station_addr <= 8'h12;
		live_status <= rnd();
		@(posedge clk);
		run(fr(8'h12, 8'h10, 2, 3, 6, 6), 0);
		run(fr(8'h12, 8'h03, 0, 47), 0);
		give_verdict();
	end
endmodule
`default_nettype wire
